// ### src/ebr_defs.vh
`ifndef EBR_DEFS_VH
`define EBR_DEFS_VH

// instruction word fields
`define EBR_INSTR_W 12
`define EBR_OPC_HI 11
`define EBR_OPC_LO 8
`define EBR_DEST_BIT 7
`define EBR_FADDR_HI 6
`define EBR_LIT_HI 7

// opcodes
`define EBR_OP_ADD 4'h0
`define EBR_OP_SUB 4'h1
`define EBR_OP_AND 4'h2
`define EBR_OP_IOR 4'h3
`define EBR_OP_XOR 4'h4
`define EBR_OP_RLF 4'h5
`define EBR_OP_RRF 4'h6
`define EBR_OP_MOVF 4'h7
`define EBR_OP_COMF 4'h8
`define EBR_OP_MOVWF 4'h9
`define EBR_OP_ADDLW 4'hA
`define EBR_OP_ANDLW 4'hB
`define EBR_OP_MOVLW 4'hC
`define EBR_OP_GOTO 4'hD

// internally held file addresses
`define EBR_FA_INDIRECT 7'h00
`define EBR_FA_PCLOW 7'h02
`define EBR_FA_STATUS 7'h03
`define EBR_FA_POINTER 7'h04

// status bit positions
`define EBR_ST_CARRY 0
`define EBR_ST_DIGIT 1
`define EBR_ST_ZERO 2

// reset values
`define EBR_RST_BYTE 8'h00
`define EBR_RST_INSTR 12'h000

`endif

// ### src/ebr_core.v
`timescale 1ns/1ps
`include "ebr_defs.vh"

module ebr_core
#(
  parameter PC_W = 11,
  parameter PROG_WORDS = 2048,
  parameter DA_W = 7
)
(
  // clock and reset
  input wire ref_clk,
  input wire resetn,
  // program bus
  output reg [PC_W-1:0] progAddr_reg,
  input wire [`EBR_INSTR_W-1:0] progData,
  // data bus, read port
  output reg [DA_W-1:0] dataAddr_reg,
  input wire [7:0] dataRdData,
  // data bus, write port
  output reg [DA_W-1:0] dataWrAddr_reg,
  output reg [7:0] dataWrData_reg,
  output reg dataWe_reg,
  // observed state
  output reg [7:0] accumulator_reg,
  output reg [7:0] status_reg,
  output reg execValid_reg
);

  // ****************************************
  // pipeline and internal file state
  // ****************************************
  reg [`EBR_INSTR_W-1:0] instr_reg;
  reg [7:0] pointer_reg;
  reg [DA_W-1:0] effAddr_reg;

  wire [3:0] opc = instr_reg[`EBR_OPC_HI:`EBR_OPC_LO];
  wire toFile = instr_reg[`EBR_DEST_BIT];
  wire [7:0] lit = instr_reg[`EBR_LIT_HI:0];
  wire [DA_W-1:0] fetchAddr = progData[`EBR_FADDR_HI:0];

  // next sequential address, wrapping inside the store for odd sizes such as 384
  wire [31:0] lastAddrFull = PROG_WORDS - 1;
  wire [PC_W-1:0] lastAddr = lastAddrFull[PC_W-1:0];
  wire [PC_W-1:0] pcInc = (progAddr_reg == lastAddr) ? {PC_W{1'b0}} :
                          progAddr_reg + 1'b1;

  // ****************************************
  // file read, internal files or data port
  // ****************************************
  // a write issued last cycle lands at the same edge we read, so forward it
  wire fwdHit = dataWe_reg && (dataWrAddr_reg == dataAddr_reg);
  reg [7:0] fileVal;

  // internal files answer in place of the data port
  always @*
  begin
    case (effAddr_reg)
      `EBR_FA_INDIRECT: fileVal = `EBR_RST_BYTE; // pointer to itself reads zero
      `EBR_FA_PCLOW: fileVal = progAddr_reg[7:0];
      `EBR_FA_STATUS: fileVal = status_reg;
      `EBR_FA_POINTER: fileVal = pointer_reg;
      default: fileVal = fwdHit ? dataWrData_reg : dataRdData;
    endcase
  end

  // ****************************************
  // ALU and write-back decode
  // ****************************************
  reg [7:0] res;
  reg [8:0] sum9;
  reg [4:0] sum5;
  reg [7:0] opB;
  reg cin;
  reg wrAcc;
  reg wrFile;
  reg setC;
  reg setDigit;
  reg setZ;
  reg newC;
  reg newDigit;
  reg isBranch;
  reg [PC_W-1:0] target;

  // one-cycle ALU; operand from file or literal against the accumulator
  always @*
  begin
    res = `EBR_RST_BYTE;
    opB = accumulator_reg;
    cin = 1'b0;
    wrAcc = 1'b0;
    wrFile = 1'b0;
    setC = 1'b0;
    setDigit = 1'b0;
    setZ = 1'b0;
    newC = status_reg[`EBR_ST_CARRY];
    newDigit = status_reg[`EBR_ST_DIGIT];
    isBranch = 1'b0;
    target = progAddr_reg;
    // subtract as file plus inverted accumulator plus one
    if (opc == `EBR_OP_SUB)
    begin
      opB = ~accumulator_reg;
      cin = 1'b1;
    end
    sum9 = {1'b0, (opc == `EBR_OP_ADDLW) ? lit : fileVal} + {1'b0, opB} + {8'h00, cin};
    sum5 = {1'b0, (opc == `EBR_OP_ADDLW) ? lit[3:0] : fileVal[3:0]} + {1'b0, opB[3:0]}
           + {4'h0, cin};
    case (opc)
      `EBR_OP_ADD, `EBR_OP_SUB, `EBR_OP_ADDLW:
      begin
        res = sum9[7:0];
        newC = sum9[8]; // carry, or no-borrow on subtract
        newDigit = sum5[4]; // nibble carry or no-borrow
        setC = 1'b1;
        setDigit = 1'b1;
        setZ = 1'b1;
      end
      `EBR_OP_AND: begin res = fileVal & accumulator_reg; setZ = 1'b1; end
      `EBR_OP_IOR: begin res = fileVal | accumulator_reg; setZ = 1'b1; end
      `EBR_OP_XOR: begin res = fileVal ^ accumulator_reg; setZ = 1'b1; end
      `EBR_OP_ANDLW: begin res = lit & accumulator_reg; setZ = 1'b1; end
      `EBR_OP_RLF:
      begin
        res = {fileVal[6:0], status_reg[`EBR_ST_CARRY]}; // shift through carry
        newC = fileVal[7];
        setC = 1'b1;
      end
      `EBR_OP_RRF:
      begin
        res = {status_reg[`EBR_ST_CARRY], fileVal[7:1]};
        newC = fileVal[0];
        setC = 1'b1;
      end
      `EBR_OP_MOVF: begin res = fileVal; setZ = 1'b1; end
      `EBR_OP_COMF: begin res = ~fileVal; setZ = 1'b1; end
      `EBR_OP_MOVWF: res = accumulator_reg;
      `EBR_OP_MOVLW: res = lit;
      `EBR_OP_GOTO:
      begin
        isBranch = 1'b1;
        target = {progAddr_reg[PC_W-1:8], lit};
      end
      default: res = `EBR_RST_BYTE; // unused codes act as no-op
    endcase
    // destination: literal ops always to the accumulator
    if (opc == `EBR_OP_ADDLW || opc == `EBR_OP_ANDLW || opc == `EBR_OP_MOVLW)
      wrAcc = 1'b1;
    else if (opc == `EBR_OP_MOVWF)
      wrFile = 1'b1;
    else if (opc != `EBR_OP_GOTO && opc <= `EBR_OP_COMF)
    begin
      wrFile = toFile;
      wrAcc = ~toFile;
    end
    // a write to the low program counter byte is a computed branch
    if (wrFile && effAddr_reg == `EBR_FA_PCLOW)
    begin
      isBranch = 1'b1;
      target = {progAddr_reg[PC_W-1:8], res};
    end
    if (!execValid_reg)
    begin
      wrAcc = 1'b0;
      wrFile = 1'b0;
      setC = 1'b0;
      setDigit = 1'b0;
      setZ = 1'b0;
      isBranch = 1'b0;
    end
  end

  // ****************************************
  // next values of the internal files
  // ****************************************
  reg [7:0] statusNext;
  reg [7:0] pointerNext;

  // flag updates win over a plain write of the status file
  always @*
  begin
    statusNext = status_reg;
    pointerNext = pointer_reg;
    if (wrFile && effAddr_reg == `EBR_FA_STATUS)
      statusNext = res;
    if (wrFile && effAddr_reg == `EBR_FA_POINTER)
      pointerNext = res;
    if (setC)
      statusNext[`EBR_ST_CARRY] = newC;
    if (setDigit)
      statusNext[`EBR_ST_DIGIT] = newDigit;
    if (setZ)
      statusNext[`EBR_ST_ZERO] = (res == `EBR_RST_BYTE);
  end

  // operand address of the word being fetched; uses the pointer value being
  // written now so a pointer load followed by an indirect access needs no stall
  wire [DA_W-1:0] effAddrNext = (fetchAddr == `EBR_FA_INDIRECT) ?
                                pointerNext[DA_W-1:0] : fetchAddr;

  wire isInternal = (effAddr_reg == `EBR_FA_INDIRECT) || (effAddr_reg == `EBR_FA_PCLOW) ||
                    (effAddr_reg == `EBR_FA_STATUS) || (effAddr_reg == `EBR_FA_POINTER);

  // ****************************************
  // fetch, execute and write-back registers
  // ****************************************
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      progAddr_reg <= {PC_W{1'b0}};
      instr_reg <= `EBR_RST_INSTR;
      execValid_reg <= 1'b0;
      effAddr_reg <= {DA_W{1'b0}};
      dataAddr_reg <= {DA_W{1'b0}};
      dataWrAddr_reg <= {DA_W{1'b0}};
      dataWrData_reg <= `EBR_RST_BYTE;
      dataWe_reg <= 1'b0;
      accumulator_reg <= `EBR_RST_BYTE;
      status_reg <= `EBR_RST_BYTE;
      pointer_reg <= `EBR_RST_BYTE;
    end
    else
    begin
      // whole word captured each cycle while the previous one executes
      instr_reg <= progData;
      effAddr_reg <= effAddrNext;
      dataAddr_reg <= effAddrNext; // read address runs beside the fetch
      if (isBranch)
      begin
        progAddr_reg <= target; // refetch from the target
        execValid_reg <= 1'b0; // drop the word already fetched
      end
      else
      begin
        progAddr_reg <= pcInc; // one instruction per cycle
        execValid_reg <= 1'b1;
      end
      if (wrAcc)
        accumulator_reg <= res; // no file address reaches it
      status_reg <= statusNext;
      pointer_reg <= pointerNext;
      // external files written one cycle later, on their own write port
      dataWe_reg <= wrFile && !isInternal;
      dataWrAddr_reg <= effAddr_reg;
      dataWrData_reg <= res;
    end
  end

endmodule

// ### bench/ebr_core_props.sv
`timescale 1ns/1ps
// ****************
// core timing checks
// ****************
module ebr_core_props #(parameter PC_W = 11, parameter PROG_WORDS = 2048, parameter DA_W = 7)
(
  // clock and reset
  input logic ref_clk,
  input logic resetn,
  // buses
  input logic [PC_W-1:0] progAddr_reg,
  input logic [11:0] progData,
  input logic [DA_W-1:0] dataAddr_reg,
  input logic [7:0] dataRdData,
  input logic [DA_W-1:0] dataWrAddr_reg,
  input logic [7:0] dataWrData_reg,
  input logic dataWe_reg,
  // observed state
  input logic [7:0] accumulator_reg,
  input logic [7:0] status_reg,
  input logic execValid_reg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // opcode of the word now executing, valid only with execValid
  branch_flush_a: assert property (execValid_reg && $past(progData[11:8]) == 4'hD |=>
    !execValid_reg) else $error("branch did not flush the prefetched word");
  branch_target_a: assert property (execValid_reg && $past(progData[11:8]) == 4'hD |=>
    progAddr_reg == {$past(progAddr_reg[PC_W-1:8]), $past(progData[7:0], 2)})
    else $error("branch target wrong");
  seq_fetch_a: assert property (execValid_reg && $past(progData[11:8]) inside {4'hA, 4'hB, 4'hC}
    |=> execValid_reg && !dataWe_reg && progAddr_reg == ($past(progAddr_reg) + 1) % PROG_WORDS)
    else $error("literal op did not complete in one cycle");
  literal_load_a: assert property (execValid_reg && $past(progData[11:8]) == 4'hC |=>
    accumulator_reg == $past(progData[7:0], 2)) else $error("literal load wrong");
  add_carry_a: assert property (execValid_reg && $past(progData[11:8]) == 4'hA |=>
    {status_reg[0], accumulator_reg} == $past(accumulator_reg) + $past(progData[7:0], 2)
    && status_reg[2] == (accumulator_reg == 8'h00)) else $error("literal add result or flags wrong");
  add_digit_a: assert property (execValid_reg && $past(progData[11:8]) == 4'hA |=>
    status_reg[1] == ($past(accumulator_reg[3:0]) + $past(progData[3:0], 2) > 15))
    else $error("digit carry wrong");
  and_logic_a: assert property (execValid_reg && $past(progData[11:8]) == 4'hB |=>
    accumulator_reg == ($past(accumulator_reg) & $past(progData[7:0], 2))
    && status_reg[0] == $past(status_reg[0])) else $error("literal and wrong");
  file_write_a: assert property (execValid_reg && $past(progData[11:8]) == 4'h9
    && $past(progData[6:0]) > 7'h04 |=> dataWe_reg && dataWrData_reg == $past(accumulator_reg)
    && dataWrAddr_reg == $past(progData[6:0], 2)) else $error("file write wrong");
  internal_we_a: assert property (dataWe_reg |->
    !(dataWrAddr_reg inside {7'h00, 7'h02, 7'h03, 7'h04})) else $error("internal file written out");
endmodule

bind ebr_core ebr_core_props #(.PC_W(PC_W), .PROG_WORDS(PROG_WORDS), .DA_W(DA_W)) chk
(
  .ref_clk(ref_clk), .resetn(resetn), .progAddr_reg(progAddr_reg), .progData(progData),
  .dataAddr_reg(dataAddr_reg), .dataRdData(dataRdData), .dataWrAddr_reg(dataWrAddr_reg),
  .dataWrData_reg(dataWrData_reg), .dataWe_reg(dataWe_reg), .accumulator_reg(accumulator_reg),
  .status_reg(status_reg), .execValid_reg(execValid_reg)
);

// ### bench/ebr_mem_model.sv
`timescale 1ns/1ps
// ****************
// program store and data file
// ****************
module ebr_mem_model
(
  // clock
  input wire logic ref_clk,
  // program side
  input wire logic [10:0] progAddr,
  output logic [11:0] progData,
  // data side
  input wire logic [6:0] dataAddr,
  output logic [7:0] dataRdData,
  input wire logic [6:0] dataWrAddr,
  input wire logic [7:0] dataWrData,
  input wire logic dataWe
);
  logic [11:0] rom [0:2047];
  logic [7:0] ram [0:127];
  // async reads, so the word is there in the fetch cycle
  assign progData = rom[progAddr];
  assign dataRdData = ram[dataAddr];
  // commit at the edge that ends the strobe cycle
  always @(posedge ref_clk)
    if (dataWe)
      ram[dataWrAddr] <= dataWrData;
endmodule

// ### bench/ebr_core_test.sv
`timescale 1ns/1ps
// ****************
// self-checking bench
// ****************
module ebr_core_test;
  logic ref_clk, resetn;
  wire [10:0] progAddr;
  wire [11:0] progData;
  wire [6:0] dataAddr, dataWrAddr;
  wire [7:0] dataRdData, dataWrData, acc, status;
  wire dataWe, execValid;
  int failures = 0;
  int n_checks = 0;
  ebr_core dut (.ref_clk(ref_clk), .resetn(resetn), .progAddr_reg(progAddr),
    .progData(progData), .dataAddr_reg(dataAddr), .dataRdData(dataRdData),
    .dataWrAddr_reg(dataWrAddr), .dataWrData_reg(dataWrData), .dataWe_reg(dataWe),
    .accumulator_reg(acc), .status_reg(status), .execValid_reg(execValid));
  ebr_mem_model mem (.ref_clk(ref_clk), .progAddr(progAddr), .progData(progData),
    .dataAddr(dataAddr), .dataRdData(dataRdData), .dataWrAddr(dataWrAddr),
    .dataWrData(dataWrData), .dataWe(dataWe));
  initial
  begin
    ref_clk = 0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // load a program, reset for 12 cycles, run until the spin address is fetched
  task automatic run(input logic [11:0] prog [], input logic [10:0] spin);
    int i;
    for (i = 0; i < 2048; i++)
      mem.rom[i] = (i < prog.size()) ? prog[i] : 12'hF00;
    resetn = 0;
    repeat (12) @(posedge ref_clk);
    #2 resetn = 1;
    // look a little after the edge so the new address has settled
    for (i = 0; i < 60 && progAddr !== spin; i++)
    begin
      @(posedge ref_clk);
      #2;
    end
    if (i == 60)
    begin
      failures++;
      $display("[FAIL] spin address expected %h seen %h", spin, progAddr);
      tally_and_finish();
    end
    repeat (6) @(posedge ref_clk);
    #2;
  endtask
  // add with both carries, subtract, branch skipping a prefetched load, rotate
  task automatic test_add_branch();
    run('{12'hC05, 12'h910, 12'hAFB, 12'hC03, 12'h110, 12'hD09, 12'hCEE, 12'hCEE, 12'hCEE,
      12'h590, 12'hD0A}, 11'h00A);
    check("acc", acc, 8'h02);
    check("status", status, 8'h02);
    check("file10", mem.ram[16], 8'h0B);
    $display("test_add_branch done");
  endtask
  // borrow on subtraction, then indirect complement through the pointer
  task automatic test_sub_indirect();
    run('{12'hC01, 12'h911, 12'hC02, 12'h191, 12'hC11, 12'h904, 12'h800, 12'hD07}, 11'h007);
    check("file11", mem.ram[17], 8'hFF);
    check("acc", acc, 8'h00);
    check("status", status, 8'h04);
    $display("test_sub_indirect done");
  endtask
  // forwarded reads, logic ops, rotate right, computed branch, status write
  task automatic test_logic_forward();
    run('{12'hC3C, 12'h912, 12'hC0F, 12'h892, 12'h212, 12'h492, 12'h412, 12'hB81,
      12'h913, 12'h693, 12'hC0D, 12'h902, 12'hCEE, 12'h313, 12'h903, 12'hD0F}, 11'h00F);
    check("file12", mem.ram[18], 8'hC0);
    check("file13", mem.ram[19], 8'h40);
    check("acc", acc, 8'h4D);
    check("status", status, 8'h4D);
    $display("test_logic_forward done");
  endtask
  initial
  begin
    test_add_branch();
    test_sub_indirect();
    test_logic_forward();
    tally_and_finish();
  end
endmodule
